/* File: pmev_defines.svh */
`ifndef PMEV_DEFINES_SVH
`define PMEV_DEFINES_SVH
// register offsets within the control space
`define PMEV_OFS_STATUS     16'h8500
`define PMEV_OFS_PKT_CTRL   16'h8504
`define PMEV_OFS_CLK_STOP   16'h8508
// status flag positions
`define PMEV_BIT_PIN        0
`define PMEV_BIT_IO         1
`define PMEV_BIT_MEM        2
// packet control and clock-stop field positions
`define PMEV_BIT_VIDEO_EVENT_ENABLE     0
`define PMEV_BIT_CPU_EN     1
`define PMEV_BIT_CPU_RD     2
`define PMEV_BIT_IVL_LO     3
`define PMEV_BIT_IVL_HI     4
`define PMEV_BIT_XTEST      5
`define PMEV_BIT_CSTP       0
// packet bit positions
`define PMEV_PKT_VID_DEC    0
`define PMEV_PKT_USR_DEF    1
`define PMEV_PKT_CPU_ACT    6
`define PMEV_PKT_VID_IRQ    7
// reset value of the low byte
`define PMEV_RST_BYTE       8'h00
// interval codes
`define PMEV_IVL_OFF        2'h0
`define PMEV_IVL_1MS        2'h1
`define PMEV_IVL_5MS        2'h2
`define PMEV_IVL_10MS       2'h3
// timing: clock in kHz and interval in ms
`define PMEV_CLK_KHZ        40000
`define PMEV_T1_MS          1
`define PMEV_T5_MS          5
`define PMEV_T10_MS         10
`define PMEV_START_CYC      4'h2
`define PMEV_LAST_BIT       3'h7
`define PMEV_FIFO_DEPTH     4
`endif

/* File: pmev_pkg.sv */
package pmev_pkg;
	typedef enum logic [3:0] {
		PMEV_IDLE  = 4'b0001,
		PMEV_START = 4'b0010,
		PMEV_SHIFT = 4'b0100,
		PMEV_END   = 4'b1000
	} pmev_state_t;
endpackage

/* File: pmev_fifo.sv */
`timescale 1ns/100ps
// small flop fifo; ready low when full pushes back on the source
module pmev_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk_in,
	input  wire logic             arst_n_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// handshake terms
	assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem_q[rd_q];

	// storage written at the tail
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	// pointers and fill level
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* File: pmev_regs.sv */
`timescale 1ns/100ps
`include "pmev_defines.svh"
// Functional notes
// - set memory-emulation flag, bit 2, on graphics-memory emulation interrupt
// - set I/O-emulation flag, bit 1, on I/O emulation interrupt
// - set external-pin flag, bit 0, when request pin goes active
// - cause flags clear only by writing one; zero leaves them
// - writing one to bit 5 sends the packet at once
// - bit 5 reads back zero always
// - bits 4:3 pick interval: off, 1 ms, 5 ms, 10 ms
// - data-read misses reported only with read enable; fetches never
// - read enable ignored unless master enable is set
// - master enable records non-fetch misses in packet bit 6
// - video enable lets video decode events into packet bit 0
// - clock-stop bit 0 keeps memory and display clocks in suspend
// - clock-stop bit 1 allows system clock to halt in suspend; bit 1 is not stored here and reads zero
// - reset clears low eight bits of every register
// - line low until interval, then high two clocks as start mark
// - shift bits 7 to 0, one-clock high end mark, then clear
// - interval send only with a packet bit set and interval over
// - packet bits hold until handed to the fifo; events accumulate
module pmev_regs (
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [15:0] reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [31:0] reg_wdata_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic        emul_mem_event_in,
	input  wire logic        emul_io_event_in,
	input  wire logic        mgmt_interrupt_request_pin_n_in,
	input  wire logic        cache_miss_in,
	input  wire logic        cache_miss_read_in,
	input  wire logic        cache_miss_fetch_in,
	input  wire logic        video_decode_in,
	input  wire logic        user_decode_in,
	input  wire logic        video_irq_in,
	output logic             packet_serial_out,
	output logic             suspend_clock_stop_mode_out,
	output logic             pkt_busy_out
);
	logic [2:0]           cause_q;
	logic [4:0]           ctrl_q;
	logic                 cstp_q;
	logic [7:0]           pkt_q;
	logic [7:0]           pkt_d;
	logic [18:0]          ivl_cnt_q;
	logic [18:0]          ivl_lim;
	logic                 ivl_done;
	logic                 xtest_q;
	logic                 fifo_in_valid;
	logic                 fifo_in_ready;
	logic [7:0]           fifo_data;
	logic                 fifo_valid;
	logic                 fifo_ready;
	logic [7:0]           shift_q;
	logic [2:0]           bit_q;
	logic [3:0]           start_q;
	logic                 sout_q;
	logic                 wr_stat;
	logic                 wr_ctrl;
	logic                 wr_cstp;
	logic                 cpu_act;
	logic [2:0]           cause_set;
	logic                 rd_stat;
	logic                 rd_ctrl;
	logic                 rd_cstp;
	pmev_pkg::pmev_state_t state_q;

	// register map, low byte only; bits 31:8 are never stored
	// status word at the first offset:
	//   bit 2 memory emulation cause, bit 1 i/o emulation cause
	//   bit 0 external request pin cause, bits 7:3 read zero
	//   each cause bit is sticky and clears on a written one
	// packet control word at the second offset:
	//   bit 5 test send, write only, always reads zero
	//   bits 4:3 interval code: off, 1 ms, 5 ms, 10 ms
	//   bit 2 read-miss reporting, ignored without bit 1
	//   bit 1 cache-activity master enable
	//   bit 0 video event enable
	// clock-stop word at the third offset:
	//   bit 0 suspend clock-stop mode, the rest read zero
	// packet byte, cleared once handed to the fifo:
	//   bit 7 vertical sync, bit 6 cache activity
	//   bit 1 address-range decode, bit 0 video decode
	// limitation: the interval is counted from the last handover,
	//   so a test send also restarts the interval
	// limitation: a test send goes out even with an empty packet,
	//   which lets the far side check framing on its own
	// hazard: the interval counter holds at its limit when the fifo
	//   is full, so no send is dropped, only delayed

	localparam logic [18:0] CYC_1MS  = 19'(`PMEV_CLK_KHZ * `PMEV_T1_MS);
	localparam logic [18:0] CYC_5MS  = 19'(`PMEV_CLK_KHZ * `PMEV_T5_MS);
	localparam logic [18:0] CYC_10MS = 19'(`PMEV_CLK_KHZ * `PMEV_T10_MS);

	// address decode shared by reads and writes
	function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
		hit = (a == o);
	endfunction

	assign wr_stat = reg_wr_in && hit(reg_addr_in, `PMEV_OFS_STATUS);
	assign wr_ctrl = reg_wr_in && hit(reg_addr_in, `PMEV_OFS_PKT_CTRL);
	assign wr_cstp = reg_wr_in && hit(reg_addr_in, `PMEV_OFS_CLK_STOP);

	// read strobes per register, decoded once for the read mux
	assign rd_stat = reg_rd_in && hit(reg_addr_in, `PMEV_OFS_STATUS);
	assign rd_ctrl = reg_rd_in && hit(reg_addr_in, `PMEV_OFS_PKT_CTRL);
	assign rd_cstp = reg_rd_in && hit(reg_addr_in, `PMEV_OFS_CLK_STOP);

	// raw cause inputs, the request pin taken active low
	assign cause_set = {emul_mem_event_in,
		emul_io_event_in,
		~mgmt_interrupt_request_pin_n_in};

	// cause flags: set beats write-one clear so no event is lost
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cause_q <= 3'h0;
		end else begin
			cause_q <= (cause_q & ~(wr_stat ? reg_wdata_in[2:0] : 3'h0))
				| cause_set;
		end
	end

	// packet control and clock-stop; upper bits are never stored
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_q  <= 5'h00;
			cstp_q  <= 1'b0;
			xtest_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_in[`PMEV_BIT_XTEST-1:0];
			end
			if (wr_cstp) begin
				cstp_q <= reg_wdata_in[`PMEV_BIT_CSTP];
			end
			// test request held until the fifo accepts it
			if (wr_ctrl && reg_wdata_in[`PMEV_BIT_XTEST]) begin
				xtest_q <= 1'b1;
			end else if (fifo_in_ready) begin
				xtest_q <= 1'b0;
			end
		end
	end

	// mode bit goes straight out to the suspend sequencer
	assign suspend_clock_stop_mode_out = cstp_q;

	// read mux; test bit and reserved bits read zero
	always_comb begin
		reg_rdata_out = 32'h0;
		if (rd_stat) begin
			reg_rdata_out[2:0] = cause_q;
		end else if (rd_ctrl) begin
			reg_rdata_out[4:0] = ctrl_q;
		end else if (rd_cstp) begin
			reg_rdata_out[`PMEV_BIT_CSTP] = cstp_q;
		end
	end

	// cache activity: fetches never count, reads need both enables
	assign cpu_act = ctrl_q[`PMEV_BIT_CPU_EN] && cache_miss_in
		&& !cache_miss_fetch_in
		&& (!cache_miss_read_in || ctrl_q[`PMEV_BIT_CPU_RD]);

	// interval limit per code
	always_comb begin
		unique case (ctrl_q[`PMEV_BIT_IVL_HI:`PMEV_BIT_IVL_LO])
			`PMEV_IVL_OFF:  ivl_lim = 19'h0;
			`PMEV_IVL_1MS:  ivl_lim = CYC_1MS - 19'h1;
			`PMEV_IVL_5MS:  ivl_lim = CYC_5MS - 19'h1;
			`PMEV_IVL_10MS: ivl_lim = CYC_10MS - 19'h1;
		endcase
	end

	// interval over only while a code other than off is selected
	assign ivl_done = (ctrl_q[`PMEV_BIT_IVL_HI:`PMEV_BIT_IVL_LO] != `PMEV_IVL_OFF)
		&& (ivl_cnt_q >= ivl_lim);

	// interval counter holds at the limit until a send empties the packet
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ivl_cnt_q <= 19'h0;
		end else if (fifo_in_valid && fifo_in_ready) begin
			ivl_cnt_q <= 19'h0;
		end else if (!ivl_done) begin
			ivl_cnt_q <= ivl_cnt_q + 19'h1;
		end
	end

	// hand the snapshot over when it holds a bit and time is up, or on test
	assign fifo_in_valid = xtest_q || (ivl_done && (pkt_q != 8'h00));

	// packet bits accumulate; the handed-over snapshot is cleared
	always_comb begin
		pkt_d = pkt_q;
		if (fifo_in_valid && fifo_in_ready) begin
			pkt_d = 8'h00;
		end
		pkt_d[`PMEV_PKT_VID_DEC] = pkt_d[`PMEV_PKT_VID_DEC]
			| (video_decode_in && ctrl_q[`PMEV_BIT_VIDEO_EVENT_ENABLE]);
		pkt_d[`PMEV_PKT_USR_DEF] = pkt_d[`PMEV_PKT_USR_DEF] | user_decode_in;
		pkt_d[`PMEV_PKT_CPU_ACT] = pkt_d[`PMEV_PKT_CPU_ACT] | cpu_act;
		pkt_d[`PMEV_PKT_VID_IRQ] = pkt_d[`PMEV_PKT_VID_IRQ] | video_irq_in;
	end

	// packet byte register
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pkt_q <= `PMEV_RST_BYTE;
		end else begin
			pkt_q <= pkt_d;
		end
	end

	// snapshots queue here while a frame is still on the line
	pmev_fifo #(
		.WIDTH (8),
		.DEPTH (`PMEV_FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in    (ref_clk_in),
		.arst_n_in     (arst_n_in),
		.in_data_in    (pkt_q),
		.in_valid_in   (fifo_in_valid),
		.in_ready_out  (fifo_in_ready),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_ready)
	);

	// serialiser pulls a byte only when idle, so the fifo can fill
	assign fifo_ready   = (state_q == pmev_pkg::PMEV_IDLE);
	assign pkt_busy_out = (state_q != pmev_pkg::PMEV_IDLE);

	// frame sequencer: start mark, eight bits, end mark
	// the end state always gives one low cycle before the next start,
	// so the far side can find the next frame edge
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= pmev_pkg::PMEV_IDLE;
			shift_q <= 8'h00;
			bit_q   <= 3'h0;
			start_q <= 4'h0;
		end else begin
			unique case (state_q)
				pmev_pkg::PMEV_IDLE: begin
					if (fifo_valid) begin
						shift_q <= fifo_data;
						start_q <= 4'h1;
						state_q <= pmev_pkg::PMEV_START;
					end
				end
				pmev_pkg::PMEV_START: begin
					start_q <= start_q + 4'h1;
					if (start_q == `PMEV_START_CYC) begin
						bit_q   <= `PMEV_LAST_BIT;
						state_q <= pmev_pkg::PMEV_SHIFT;
					end
				end
				pmev_pkg::PMEV_SHIFT: begin
					bit_q <= bit_q - 3'h1;
					if (bit_q == 3'h0) begin
						state_q <= pmev_pkg::PMEV_END;
					end
				end
				pmev_pkg::PMEV_END: begin
					state_q <= pmev_pkg::PMEV_IDLE;
				end
				default: state_q <= pmev_pkg::PMEV_IDLE;
			endcase
		end
	end

	// registered line: start high, msb first, one-clock end mark
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sout_q <= 1'b0;
		end else begin
			unique case (state_q)
				pmev_pkg::PMEV_IDLE:  sout_q <= fifo_valid;
				pmev_pkg::PMEV_START: sout_q <= (start_q == `PMEV_START_CYC)
					? shift_q[`PMEV_LAST_BIT] : 1'b1;
				pmev_pkg::PMEV_SHIFT: sout_q <= (bit_q == 3'h0)
					? 1'b1 : shift_q[bit_q - 3'h1];
				pmev_pkg::PMEV_END:   sout_q <= 1'b0;
				default:              sout_q <= 1'b0;
			endcase
		end
	end

	assign packet_serial_out = sout_q;
endmodule

/* File: pmev_regs_monitor.sv */
`timescale 1ns/100ps
`include "pmev_defines.svh"
// port checks: register reads, cause flags, serial framing
module pmev_regs_monitor (
	input wire logic        ref_clk_in,
	input wire logic        arst_n_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        emul_mem_event_in,
	input wire logic        emul_io_event_in,
	input wire logic        mgmt_interrupt_request_pin_n_in,
	input wire logic        cache_miss_in,
	input wire logic        cache_miss_read_in,
	input wire logic        cache_miss_fetch_in,
	input wire logic        video_decode_in,
	input wire logic        user_decode_in,
	input wire logic        video_irq_in,
	input wire logic        packet_serial_out,
	input wire logic        suspend_clock_stop_mode_out,
	input wire logic        pkt_busy_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	logic rs;
	logic rp;
	logic wc;
	logic mapped;
	// decoded accesses, so the properties stay short
	assign rs = reg_rd_in && reg_addr_in == `PMEV_OFS_STATUS;
	assign rp = reg_rd_in && reg_addr_in == `PMEV_OFS_PKT_CTRL;
	assign wc = reg_wr_in && reg_addr_in == `PMEV_OFS_CLK_STOP;
	assign mapped = rs || rp || reg_addr_in == `PMEV_OFS_CLK_STOP;
	sequence start_s;
		packet_serial_out ##1 packet_serial_out;
	endsequence
	sequence end_s;
		packet_serial_out ##1 !packet_serial_out;
	endsequence
	frame_shape_a: assert property ($rose(pkt_busy_out) |-> start_s ##9 end_s)
		else $error("serial frame shape wrong");
	idle_low_a: assert property (!pkt_busy_out |-> !packet_serial_out)
		else $error("line high while idle");
	rd_quiet_a: assert property (!reg_rd_in || !mapped |-> reg_rdata_out == '0)
		else $error("read data not zero");
	xtest_zero_a: assert property (rp |-> !reg_rdata_out[5])
		else $error("test bit reads one");
	pin_flag_a: assert property (rs && $past(!mgmt_interrupt_request_pin_n_in) |-> reg_rdata_out[0])
		else $error("pin flag not set");
	mem_flag_a: assert property (rs && $past(emul_mem_event_in) |-> reg_rdata_out[2])
		else $error("memory flag not set");
	io_flag_a: assert property (rs && $past(emul_io_event_in) |-> reg_rdata_out[1])
		else $error("io flag not set");
	clk_stop_a: assert property ($past(wc) |-> suspend_clock_stop_mode_out == $past(reg_wdata_in[0]))
		else $error("clock stop mode wrong");
endmodule
bind pmev_regs pmev_regs_monitor u_mon (.*);

/* File: pmev_companion_rx.sv */
`timescale 1ns/100ps
// receiver on the far side; any framing slip sets a sticky error
module pmev_companion_rx (
	input  wire logic       ref_clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       line_in,
	output logic      [7:0] byte_out,
	output logic            got_out,
	output logic            bad_out
);
	logic [3:0] cnt_q;
	// count frame cycles from the first start-mark cycle
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= 4'h0;
			byte_out <= 8'h00;
			got_out <= 1'b0;
			bad_out <= 1'b0;
		end else begin
			got_out <= cnt_q == 4'hb;
			if (cnt_q == 4'h0) begin
				cnt_q <= {3'h0, line_in};
			end else begin
				cnt_q <= (cnt_q == 4'hb) ? 4'h0 : cnt_q + 4'h1;
			end
			if (cnt_q >= 4'h2 && cnt_q <= 4'h9) begin
				byte_out <= {byte_out[6:0], line_in};
			end
			if ((cnt_q == 4'h1 || cnt_q == 4'ha) && !line_in) begin
				bad_out <= 1'b1;
			end
			if (cnt_q == 4'hb && line_in) begin
				bad_out <= 1'b1;
			end
		end
	end
endmodule

/* File: pmev_regs_tb_top.sv */
`timescale 1ns/100ps
`include "pmev_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module pmev_regs_tb_top;
	typedef struct packed {
		logic [15:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pmev_row_t;
	logic        ref_clk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [15:0] reg_addr_in = 16'h0000;
	logic        reg_wr_in = 1'b0;
	logic        reg_rd_in = 1'b0;
	logic [31:0] reg_wdata_in = 32'h0;
	logic [31:0] reg_rdata_out;
	logic [8:0]  ev = 9'h000;
	wire         mgmt_interrupt_request_pin_n_in = !ev[8];
	wire         emul_mem_event_in = ev[7];
	wire         emul_io_event_in = ev[6];
	wire         cache_miss_in = ev[5];
	wire         cache_miss_read_in = ev[4];
	wire         cache_miss_fetch_in = ev[3];
	wire         video_decode_in = ev[2];
	wire         user_decode_in = ev[1];
	wire         video_irq_in = ev[0];
	logic        packet_serial_out;
	logic        suspend_clock_stop_mode_out;
	logic        pkt_busy_out;
	logic [7:0]  rx_byte;
	logic        got;
	logic        rx_bad;
	logic [31:0] v;
	int          tests_run = 0;
	int          bad_count = 0;
	int          rx_n = 0;
	int          wk = 0;
	int          cyc = 0;
	pmev_row_t   rows [8] = '{
		'{`PMEV_OFS_CLK_STOP, 32'h1, 32'h1},
		'{`PMEV_OFS_CLK_STOP, 32'h0, 32'h0},
		'{`PMEV_OFS_PKT_CTRL, 32'h1f, 32'h1f},
		'{`PMEV_OFS_PKT_CTRL, 32'h08, 32'h08},
		'{`PMEV_OFS_PKT_CTRL, 32'h10, 32'h10},
		'{`PMEV_OFS_PKT_CTRL, 32'h27, 32'h07},
		'{`PMEV_OFS_STATUS, 32'h7, 32'h0},
		'{16'h850c, 32'hff, 32'h0}
	};
	pmev_regs DUT (.*);
	pmev_companion_rx u_rx (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.line_in(packet_serial_out), .byte_out(rx_byte), .got_out(got),
		.bad_out(rx_bad));
	// 40 MHz clock
	always #12.5 ref_clk_in = ~ref_clk_in;
	// frame counter and hang guard
	always @(posedge ref_clk_in) begin
		cyc++;
		if (got) rx_n++;
		if (cyc == 60000) begin
			bad_count++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk_in) #1;
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(posedge ref_clk_in) #1;
		reg_wr_in = 1'b0;
	endtask
	// read data is combinational, so it is taken mid-cycle
	task automatic cr(input string n, input logic [15:0] a, input logic [31:0] e);
		@(posedge ref_clk_in) #1;
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge ref_clk_in) v = reg_rdata_out;
		@(posedge ref_clk_in) #1;
		reg_rd_in = 1'b0;
		`CHK(n, e, v)
	endtask
	task automatic pulse(input logic [8:0] p);
		@(posedge ref_clk_in) #1;
		ev = p;
		@(posedge ref_clk_in) #1;
		ev = 9'h000;
	endtask
	task automatic wait_rx(input logic [7:0] e, input int lim);
		rx_n = 0;
		wk = 0;
		while (rx_n == 0 && wk < lim) begin
			@(posedge ref_clk_in) #1;
			wk++;
		end
		`CHK("packet", e, rx_byte)
		`CHK("frame", 1'b0, rx_bad)
	endtask
	initial begin
		repeat (12) @(posedge ref_clk_in);
		#1 arst_n_in = 1'b1;
		cr("status", `PMEV_OFS_STATUS, 32'h0);
		cr("pktctl", `PMEV_OFS_PKT_CTRL, 32'h0);
		cr("clkstop", `PMEV_OFS_CLK_STOP, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			cr("row", rows[i].a, rows[i].e);
		end
		pulse(9'h1c0);
		cr("cause", `PMEV_OFS_STATUS, 32'h7);
		wr(`PMEV_OFS_STATUS, 32'h0);
		cr("cause", `PMEV_OFS_STATUS, 32'h7);
		wr(`PMEV_OFS_STATUS, 32'h2);
		cr("cause", `PMEV_OFS_STATUS, 32'h5);
		fork
			wr(`PMEV_OFS_STATUS, 32'h4);
			pulse(9'h080);
		join
		cr("cause", `PMEV_OFS_STATUS, 32'h5);
		wr(`PMEV_OFS_STATUS, 32'h5);
		cr("cause", `PMEV_OFS_STATUS, 32'h0);
		// video on, master off: read miss must not count
		wr(`PMEV_OFS_PKT_CTRL, 32'h5);
		pulse(9'h004);
		pulse(9'h002);
		pulse(9'h002);
		pulse(9'h030);
		wr(`PMEV_OFS_PKT_CTRL, 32'h25);
		wait_rx(8'h03, 30);
		// master on, read enable off, video off
		wr(`PMEV_OFS_PKT_CTRL, 32'h2);
		pulse(9'h030);
		pulse(9'h028);
		pulse(9'h004);
		pulse(9'h001);
		pulse(9'h020);
		wr(`PMEV_OFS_PKT_CTRL, 32'h22);
		wait_rx(8'hc0, 30);
		wr(`PMEV_OFS_PKT_CTRL, 32'h0e);
		pulse(9'h030);
		wait_rx(8'h40, 40100);
		`CHK("interval", 1'b1, wk > 39900)
		// back-to-back test sends queue in the fifo
		wr(`PMEV_OFS_PKT_CTRL, 32'h0);
		rx_n = 0;
		repeat (4) wr(`PMEV_OFS_PKT_CTRL, 32'h20);
		repeat (60) @(posedge ref_clk_in);
		`CHK("frames", 4, rx_n)
		stop_test;
	end
endmodule
